// *** shared/pcs_pkg.sv ***
// constants, field positions and types for the phy config and self-test register slice
package pcs_pkg;

   // ***************************************************************
   // register indices (byte address is four times the index)
   // ***************************************************************
   localparam logic [5:0]  IDX_SPEED_FALLBACK_CONFIG = 6'h14;
   localparam logic [5:0]  IDX_RX_FAULT_COUNTER      = 6'h15;
   localparam logic [5:0]  IDX_SELF_TEST_CONTROL     = 6'h16;
   localparam int          ADDR_W                    = 8;
   localparam int          DATA_W                    = 16;

   // ***************************************************************
   // speed_fallback_config fields
   // ***************************************************************
   localparam int          CFG_IRQ_LEVEL_BIT   = 13;
   localparam int          CFG_TRY_CNT_LSB     = 10;
   localparam int          CFG_DS_EN_BIT       = 9;
   localparam int          CFG_PAIR_MODE_BIT   = 8;
   localparam int          CFG_LOWEST_BIT      = 6;
   localparam logic [5:0]  CFG_LOW_RSVD_VALUE  = 6'h07;
   localparam logic        RST_IRQ_LEVEL       = 1'b1;
   localparam logic [1:0]  RST_TRY_CNT         = 2'h2;
   localparam logic        RST_DS_EN           = 1'b0;
   localparam logic        RST_PAIR_MODE       = 1'b1;
   localparam logic        RST_LOWEST          = 1'b1;

   // ***************************************************************
   // self_test_control fields
   // ***************************************************************
   localparam int          BIST_WRAP_BIT       = 15;
   localparam int          BIST_PAYLOAD_BIT    = 14;
   localparam int          BIST_SHORT_BIT      = 13;
   localparam int          BIST_GEN_EN_BIT     = 12;
   localparam int          BIST_FAR_FWD_BIT    = 7;
   localparam int          BIST_NEAR_FWD_BIT   = 6;
   localparam int          BIST_LOOP_LSB       = 2;
   localparam int          BIST_CODING_LSB     = 0;
   localparam logic [3:0]  LOOP_REVERSE        = 4'h8;
   localparam logic [3:0]  LOOP_EXTERNAL       = 4'h4;
   localparam logic [3:0]  LOOP_ANALOG         = 4'h2;
   localparam logic [3:0]  LOOP_DIGITAL        = 4'h1;
   localparam logic [15:0] RST_BIST            = 16'h0000;

   // ***************************************************************
   // counts and sizes
   // ***************************************************************
   localparam logic [10:0] FRAME_LEN_SHORT     = 11'd64;
   localparam logic [10:0] FRAME_LEN_LONG      = 11'd1518;
   localparam logic [15:0] TALLY_MAX           = 16'hFFFF;
   localparam int          PRBS_CNT_N          = 2;

   // generator sequencing
   typedef enum logic [1:0]
   {
      GEN_IDLE   = 2'b00,
      GEN_CONT   = 2'b01,
      GEN_SINGLE = 2'b10
   } pcs_gen_state_t;

   // strap capture sequencing
   typedef enum logic [1:0]
   {
      STRAP_WAIT = 2'b00,
      STRAP_DONE = 2'b01
   } pcs_strap_state_t;

endpackage

// *** shared/pcs_tally_if.sv ***
// carrier between register slice and the receive fault tally
`timescale 1ns/1ns
interface pcs_tally_if;
   logic        count_hit;
   logic        clear;
   logic [15:0] value;

   modport owner
   (
      input  count_hit,
      input  clear,
      output value
   );

   modport user
   (
      output count_hit,
      output clear,
      input  value
   );
endinterface

// *** hw/pcs_fault_counter.sv ***
// saturating receive fault tally with write-to-clear
`timescale 1ns/1ns
module pcs_fault_counter
   import pcs_pkg::*;
(
   // clock and reset
   input  wire logic   clk_sys_i,
   input  wire logic   sys_rst_i,
   // tally carrier
   pcs_tally_if.owner  tally
);

   logic [15:0] rx_fault_tally_r;
   logic [15:0] rx_fault_tally_nxt;

   // add one unless already at the top
   function automatic logic [15:0] sat_inc(input logic [15:0] v);
      sat_inc = (v == TALLY_MAX) ? v : 16'(v + 16'h0001);
   endfunction

   // *****************************************************
   // next tally: a hit in the clear cycle still counts
   // *****************************************************
   always_comb
   begin
      rx_fault_tally_nxt = rx_fault_tally_r;
      if (tally.clear)
      begin
         rx_fault_tally_nxt = 16'h0000;
      end
      if (tally.count_hit)
      begin
         rx_fault_tally_nxt = tally.clear ? 16'h0001 : sat_inc(rx_fault_tally_r);
      end
   end

   // register the tally
   always_ff @(posedge clk_sys_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         rx_fault_tally_r <= 16'h0000;
      else
         rx_fault_tally_r <= rx_fault_tally_nxt;
   end

   assign tally.value = rx_fault_tally_r;

endmodule

// *** hw/pcs_regs_top.sv ***
// register slice: speed fallback config, receive fault tally, self-test control
`timescale 1ns/1ns
// What this block does
// - reserved bits ignore writes and read zero, except config bits 5:0, which read 0x07
// - irq level bit: 1 active low, 0 active high, resets to 1
// - try count field maps 11,10,01,00 to 8,4,2,1 attempts; default 10
// - downshift enable toggles fallback; reset from strap or zero by package
// - pair energy mode adds fallback when pairs C and D lack energy
// - lowest rate bit allows 10 Mb/s fallback after gigabit and 100 failures
// - fault tally saturates at all ones, never wraps
// - any write to the tally register clears it
// - wrap mode with payload select set: counter at maximum gives a pulse and restarts from zero
// - payload select set: continuous random packets, checker always active
// - payload select clear: one constant packet, random logic inactive
// - short frame bit picks 64 byte packets, else 1518 bytes
// - generator enable starts and stops the generator
// - reverse loop forwards received packets to MAC only when far bit set
// - MAC-side loop sends looped data to line only when near bit set
// - coding loop select picks loop point by speed
module pcs_regs_top
   import pcs_pkg::*;
#(
   parameter bit STRAP_PACKAGE = 1'b0              // 1: downshift enable reset follows strap
)
(
   // clock and reset
   input  wire logic                  clk_sys_i,
   input  wire logic                  sys_rst_i,
   // register port
   input  wire logic [ADDR_W-1:0]     reg_addr_i,
   input  wire logic [DATA_W-1:0]     reg_wdata_i,
   input  wire logic                  reg_wr_i,
   input  wire logic                  reg_rd_i,
   output logic      [DATA_W-1:0]     reg_rdata_o,
   // strap and link status
   input  wire logic                  downshift_strap_i,
   input  wire logic                  link_fail_1g_i,
   input  wire logic                  link_fail_100m_i,
   input  wire logic                  no_energy_cd_i,
   input  wire logic                  speed_gig_i,
   input  wire logic                  speed_100m_i,
   // receive events and interrupt source
   input  wire logic                  rx_frame_end_i,
   input  wire logic                  rx_frame_err_i,
   input  wire logic                  irq_event_i,
   input  wire logic [PRBS_CNT_N-1:0] prbs_cnt_max_i,
   // speed fallback controls
   output logic                       irq_pin_o,
   output logic                       downshift_en_o,
   output logic [3:0]                 downshift_attempts_o,
   output logic                       fallback_pair_o,
   output logic                       fallback_10m_o,
   // self-test controls
   output logic                       gen_continuous_o,
   output logic                       gen_single_start_o,
   output logic                       prbs_gen_en_o,
   output logic                       prbs_check_en_o,
   output logic [10:0]                frame_len_o,
   output logic                       prbs_wrap_pulse_o,
   output logic [PRBS_CNT_N-1:0]      prbs_cnt_restart_o,
   // loopback controls
   output logic [3:0]                 loop_point_o,
   output logic                       rx_to_mac_o,
   output logic                       tx_to_line_o,
   output logic                       loop_post_encoder_o,
   output logic                       loop_post_scrambler_o,
   output logic                       loop_pre_scrambler_o,
   output logic                       loop_pre_dsp_o
);

   // ***************************************************************
   // register state
   // ***************************************************************
   logic                       irq_level_select_r,           irq_level_select_nxt;
   logic [1:0]                 downshift_try_count_r,        downshift_try_count_nxt;
   logic                       downshift_enable_r,           downshift_enable_nxt;
   logic                       downshift_pair_energy_mode_r, downshift_pair_energy_mode_nxt;
   logic                       downshift_to_lowest_rate_r,   downshift_to_lowest_rate_nxt;
   logic [15:0]                self_test_r,                  self_test_nxt;
   logic [DATA_W-1:0]          rdata_r,                      rdata_nxt;
   pcs_strap_state_t           strap_state_r,                strap_state_nxt;
   pcs_gen_state_t             gen_state_r,                  gen_state_nxt;
   logic                       hit_cfg;
   logic                       hit_cnt;
   logic                       hit_bist;
   logic [DATA_W-1:0]          cfg_view;

   pcs_tally_if tally ();

   // index match on an aligned word
   function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [5:0] idx);
      addr_hit = (a[1:0] == 2'b00) && (a[ADDR_W-1:2] == idx);
   endfunction

   // bits of the self-test word
   logic       wrap_mode;
   logic       payload_sel;
   logic       short_sel;
   logic       gen_en;
   logic       far_fwd;
   logic       near_fwd;
   logic [3:0] loop_sel;
   logic [1:0] coding_sel;

   assign wrap_mode   = self_test_r[BIST_WRAP_BIT];
   assign payload_sel = self_test_r[BIST_PAYLOAD_BIT];
   assign short_sel   = self_test_r[BIST_SHORT_BIT];
   assign gen_en      = self_test_r[BIST_GEN_EN_BIT];
   assign far_fwd     = self_test_r[BIST_FAR_FWD_BIT];
   assign near_fwd    = self_test_r[BIST_NEAR_FWD_BIT];
   assign loop_sel    = self_test_r[BIST_LOOP_LSB +: 4];
   assign coding_sel  = self_test_r[BIST_CODING_LSB +: 2];

   // address decode
   assign hit_cfg  = addr_hit(reg_addr_i, IDX_SPEED_FALLBACK_CONFIG);
   assign hit_cnt  = addr_hit(reg_addr_i, IDX_RX_FAULT_COUNTER);
   assign hit_bist = addr_hit(reg_addr_i, IDX_SELF_TEST_CONTROL);

   // ***************************************************************
   // fault tally
   // ***************************************************************
   assign tally.count_hit = rx_frame_end_i & rx_frame_err_i;
   assign tally.clear     = reg_wr_i & hit_cnt;

   pcs_fault_counter u_tally
   (
      .clk_sys_i (clk_sys_i),
      .sys_rst_i (sys_rst_i),
      .tally     (tally)
   );

   // config word as read back; unused bits stay zero except bits 5:0, which read 0x07
   always_comb
   begin
      cfg_view                                      = 16'h0000;
      cfg_view[CFG_IRQ_LEVEL_BIT]                   = irq_level_select_r;
      cfg_view[CFG_TRY_CNT_LSB +: 2]                = downshift_try_count_r;
      cfg_view[CFG_DS_EN_BIT]                       = downshift_enable_r;
      cfg_view[CFG_PAIR_MODE_BIT]                   = downshift_pair_energy_mode_r;
      cfg_view[CFG_LOWEST_BIT]                      = downshift_to_lowest_rate_r;
      cfg_view[5:0]                                 = CFG_LOW_RSVD_VALUE;
   end

   // ***************************************************************
   // register writes, strap capture and read path
   // ***************************************************************
   always_comb
   begin
      irq_level_select_nxt           = irq_level_select_r;
      downshift_try_count_nxt        = downshift_try_count_r;
      downshift_enable_nxt           = downshift_enable_r;
      downshift_pair_energy_mode_nxt = downshift_pair_energy_mode_r;
      downshift_to_lowest_rate_nxt   = downshift_to_lowest_rate_r;
      self_test_nxt                  = self_test_r;
      strap_state_nxt                = strap_state_r;
      rdata_nxt                      = 16'h0000;
      // strap is sampled on the first edge after release, never inside reset
      case (strap_state_r)
         STRAP_WAIT:
         begin
            if (STRAP_PACKAGE)
               downshift_enable_nxt = downshift_strap_i;
            strap_state_nxt = STRAP_DONE;
         end
         STRAP_DONE:
         begin
            strap_state_nxt = STRAP_DONE;
         end
         default:
         begin
            strap_state_nxt = STRAP_DONE;
         end
      endcase
      if (reg_wr_i && hit_cfg)
      begin
         irq_level_select_nxt           = reg_wdata_i[CFG_IRQ_LEVEL_BIT];
         downshift_try_count_nxt        = reg_wdata_i[CFG_TRY_CNT_LSB +: 2];
         downshift_enable_nxt           = reg_wdata_i[CFG_DS_EN_BIT];
         downshift_pair_energy_mode_nxt = reg_wdata_i[CFG_PAIR_MODE_BIT];
         downshift_to_lowest_rate_nxt   = reg_wdata_i[CFG_LOWEST_BIT];
      end
      if (reg_wr_i && hit_bist)
      begin
         self_test_nxt        = reg_wdata_i;
         self_test_nxt[11:8]  = 4'h0;
      end
      if (reg_rd_i)
      begin
         if (hit_cfg)
            rdata_nxt = cfg_view;
         else if (hit_cnt)
            rdata_nxt = tally.value;
         else if (hit_bist)
            rdata_nxt = self_test_r;
         else
            rdata_nxt = 16'h0000;                               // unmapped reads zero
      end
   end

   // register the software-visible state
   always_ff @(posedge clk_sys_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         irq_level_select_r           <= RST_IRQ_LEVEL;
         downshift_try_count_r        <= RST_TRY_CNT;
         downshift_enable_r           <= RST_DS_EN;
         downshift_pair_energy_mode_r <= RST_PAIR_MODE;
         downshift_to_lowest_rate_r   <= RST_LOWEST;
         self_test_r                  <= RST_BIST;
         rdata_r                      <= 16'h0000;
         strap_state_r                <= STRAP_WAIT;
      end
      else
      begin
         irq_level_select_r           <= irq_level_select_nxt;
         downshift_try_count_r        <= downshift_try_count_nxt;
         downshift_enable_r           <= downshift_enable_nxt;
         downshift_pair_energy_mode_r <= downshift_pair_energy_mode_nxt;
         downshift_to_lowest_rate_r   <= downshift_to_lowest_rate_nxt;
         self_test_r                  <= self_test_nxt;
         rdata_r                      <= rdata_nxt;
         strap_state_r                <= strap_state_nxt;
      end
   end

   assign reg_rdata_o = rdata_r;

   // ***************************************************************
   // generator sequencing
   // ***************************************************************
   logic gen_single_start_nxt;

   // one constant packet per enable or per payload drop while enabled; continuous only with random payload
   always_comb
   begin
      gen_state_nxt        = gen_state_r;
      gen_single_start_nxt = 1'b0;
      case (gen_state_r)
         GEN_IDLE:
         begin
            if (gen_en && payload_sel)
               gen_state_nxt = GEN_CONT;
            else if (gen_en)
            begin
               gen_state_nxt        = GEN_SINGLE;
               gen_single_start_nxt = 1'b1;
            end
         end
         GEN_CONT:
         begin
            if (!gen_en)
               gen_state_nxt = GEN_IDLE;
            else if (!payload_sel)
            begin
               // payload dropped while enabled: one constant packet follows
               gen_state_nxt        = GEN_SINGLE;
               gen_single_start_nxt = 1'b1;
            end
         end
         GEN_SINGLE:
         begin
            // stays spent until the enable drops or random payload is chosen
            if (!gen_en)
               gen_state_nxt = GEN_IDLE;
            else if (payload_sel)
               gen_state_nxt = GEN_CONT;
         end
         default:
         begin
            gen_state_nxt = GEN_IDLE;
         end
      endcase
   end

   // ***************************************************************
   // registered outputs
   // ***************************************************************
   logic                  irq_pin_nxt;
   logic [3:0]            attempts_nxt;
   logic                  fallback_pair_nxt;
   logic                  fallback_10m_nxt;
   logic                  wrap_pulse_nxt;
   logic [PRBS_CNT_N-1:0] restart_nxt;
   logic [3:0]            loop_point_nxt;
   logic                  rx_to_mac_nxt;
   logic                  tx_to_line_nxt;
   logic [3:0]            coding_loop_nxt;

   // all decode is registered so every output is a flop
   always_comb
   begin
      irq_pin_nxt       = irq_level_select_r ? ~irq_event_i : irq_event_i;
      case (downshift_try_count_r)
         2'b11:   attempts_nxt = 4'h8;
         2'b10:   attempts_nxt = 4'h4;
         2'b01:   attempts_nxt = 4'h2;
         default: attempts_nxt = 4'h1;
      endcase
      fallback_pair_nxt = downshift_enable_r & downshift_pair_energy_mode_r
                          & no_energy_cd_i;
      fallback_10m_nxt  = downshift_enable_r & downshift_to_lowest_rate_r
                          & link_fail_1g_i & link_fail_100m_i;
      // wrap only acts when the checker is live
      restart_nxt       = (wrap_mode && payload_sel) ? prbs_cnt_max_i : '0;
      wrap_pulse_nxt    = |restart_nxt;
      case (loop_sel)
         LOOP_REVERSE:  loop_point_nxt = LOOP_REVERSE;
         LOOP_EXTERNAL: loop_point_nxt = LOOP_EXTERNAL;
         LOOP_ANALOG:   loop_point_nxt = LOOP_ANALOG;
         LOOP_DIGITAL:  loop_point_nxt = LOOP_DIGITAL;
         default:       loop_point_nxt = 4'h0;                  // not one-hot: no loop
      endcase
      rx_to_mac_nxt     = (loop_point_nxt != LOOP_REVERSE) | far_fwd;
      tx_to_line_nxt    = (loop_point_nxt != LOOP_DIGITAL) | near_fwd;
      coding_loop_nxt   = 4'h0;
      if (speed_gig_i)
         coding_loop_nxt[3] = coding_sel[0];
      else if (speed_100m_i)
      begin
         case (coding_sel)
            2'b11:   coding_loop_nxt[0] = 1'b1;
            2'b10:   coding_loop_nxt[1] = 1'b1;
            2'b01:   coding_loop_nxt[2] = 1'b1;
            default: coding_loop_nxt    = 4'h0;
         endcase
      end
   end

   // output flops; idle values during reset
   always_ff @(posedge clk_sys_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         gen_state_r           <= GEN_IDLE;
         irq_pin_o             <= 1'b1;
         downshift_en_o        <= 1'b0;
         downshift_attempts_o  <= 4'h4;
         fallback_pair_o       <= 1'b0;
         fallback_10m_o        <= 1'b0;
         gen_continuous_o      <= 1'b0;
         gen_single_start_o    <= 1'b0;
         prbs_gen_en_o         <= 1'b0;
         prbs_check_en_o       <= 1'b0;
         frame_len_o           <= FRAME_LEN_LONG;
         prbs_wrap_pulse_o     <= 1'b0;
         prbs_cnt_restart_o    <= '0;
         loop_point_o          <= 4'h0;
         rx_to_mac_o           <= 1'b1;
         tx_to_line_o          <= 1'b1;
         loop_post_encoder_o   <= 1'b0;
         loop_post_scrambler_o <= 1'b0;
         loop_pre_scrambler_o  <= 1'b0;
         loop_pre_dsp_o        <= 1'b0;
      end
      else
      begin
         gen_state_r           <= gen_state_nxt;
         irq_pin_o             <= irq_pin_nxt;
         downshift_en_o        <= downshift_enable_r;
         downshift_attempts_o  <= attempts_nxt;
         fallback_pair_o       <= fallback_pair_nxt;
         fallback_10m_o        <= fallback_10m_nxt;
         gen_continuous_o      <= (gen_state_nxt == GEN_CONT);
         gen_single_start_o    <= gen_single_start_nxt;
         prbs_gen_en_o         <= payload_sel & gen_en;
         prbs_check_en_o       <= payload_sel;
         frame_len_o           <= short_sel ? FRAME_LEN_SHORT : FRAME_LEN_LONG;
         prbs_wrap_pulse_o     <= wrap_pulse_nxt;
         prbs_cnt_restart_o    <= restart_nxt;
         loop_point_o          <= loop_point_nxt;
         rx_to_mac_o           <= rx_to_mac_nxt;
         tx_to_line_o          <= tx_to_line_nxt;
         loop_post_encoder_o   <= coding_loop_nxt[0];
         loop_post_scrambler_o <= coding_loop_nxt[1];
         loop_pre_scrambler_o  <= coding_loop_nxt[2];
         loop_pre_dsp_o        <= coding_loop_nxt[3];
      end
   end

endmodule

// *** testbench/pcs_regs_asserts.sv ***
// port-level checks for the phy config and self-test register slice
`timescale 1ns/1ns
module pcs_regs_asserts
(
   // clock, reset and register port
   input logic        clk_sys_i,
   input logic        sys_rst_i,
   input logic [7:0]  reg_addr_i,
   input logic        reg_rd_i,
   input logic [15:0] reg_rdata_o,
   // status inputs
   input logic        no_energy_cd_i,
   input logic [1:0]  prbs_cnt_max_i,
   // controls
   input logic        downshift_en_o,
   input logic [3:0]  downshift_attempts_o,
   input logic        fallback_pair_o,
   input logic        prbs_gen_en_o,
   input logic        prbs_check_en_o,
   input logic [10:0] frame_len_o,
   input logic        prbs_wrap_pulse_o,
   input logic [1:0]  prbs_cnt_restart_o,
   input logic [3:0]  loop_point_o
);
   // one clock domain, so clock and reset are given once
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (sys_rst_i);
   property p_len;
      frame_len_o == 11'h040 || frame_len_o == 11'h5EE;
   endproperty
   a_len: assert property (p_len) else $error("frame length off");
   property p_loop;
      $onehot0(loop_point_o);
   endproperty
   a_loop: assert property (p_loop) else $error("loop point not one-hot");
   property p_tries;
      $onehot(downshift_attempts_o);
   endproperty
   a_tries: assert property (p_tries) else $error("attempt count off");
   property p_pair;
      fallback_pair_o |-> downshift_en_o && $past(no_energy_cd_i);
   endproperty
   a_pair: assert property (p_pair) else $error("pair fallback uncaused");
   property p_cfg_rsvd;
      $past(reg_rd_i && reg_addr_i == 8'h50) |-> (reg_rdata_o & 16'hD0BF) == 16'h0007;
   endproperty
   a_cfg_rsvd: assert property (p_cfg_rsvd) else $error("config reserved bits");
   property p_bist_rsvd;
      $past(reg_rd_i && reg_addr_i == 8'h58) |-> reg_rdata_o[11:8] == 4'h0;
   endproperty
   a_bist_rsvd: assert property (p_bist_rsvd) else $error("self-test reserved bits");
   property p_gen;
      prbs_gen_en_o |-> prbs_check_en_o;
   endproperty
   a_gen: assert property (p_gen) else $error("random gen without payload");
   // a restart must come from a counter at maximum and raise the pulse
   property p_restart;
      prbs_cnt_restart_o != 2'h0 |-> prbs_wrap_pulse_o
         && (prbs_cnt_restart_o & ~$past(prbs_cnt_max_i)) == 2'h0;
   endproperty
   a_restart: assert property (p_restart) else $error("restart uncaused");
endmodule
bind pcs_regs_top pcs_regs_asserts u_chk (.*);

// *** testbench/pcs_regs_top_tb.sv ***
// self-checking bench for the register slice
`timescale 1ns/1ns
module pcs_regs_top_tb
   import pcs_pkg::*;
;
   logic clk_sys_i = 0, sys_rst_i = 1, reg_wr_i = 0, reg_rd_i = 0, rd_d = 0, irq_event_i = 0;
   logic downshift_strap_i = 0, link_fail_1g_i = 0, link_fail_100m_i = 0, no_energy_cd_i = 0;
   logic speed_gig_i = 0, speed_100m_i = 0, rx_frame_end_i = 0, rx_frame_err_i = 0;
   logic [7:0] reg_addr_i = 0;
   logic [15:0] reg_wdata_i = 0, reg_rdata_o, q[$];
   logic [1:0] prbs_cnt_max_i = 0, prbs_cnt_restart_o;
   logic [3:0] downshift_attempts_o, loop_point_o, lp;
   logic [10:0] frame_len_o;
   logic irq_pin_o, downshift_en_o, fallback_pair_o, fallback_10m_o, gen_continuous_o;
   logic gen_single_start_o, prbs_gen_en_o, prbs_check_en_o, prbs_wrap_pulse_o, rx_to_mac_o;
   logic tx_to_line_o, loop_post_encoder_o, loop_post_scrambler_o, loop_pre_scrambler_o;
   logic loop_pre_dsp_o;
   logic [15:0] tw[3] = '{16'hF000, 16'h9000, 16'hC000};
   logic [18:0] te[3] = '{{2'h0, 2'h3, 4'hF, 11'h040}, {2'h1, 2'h0, 4'h0, 11'h5EE},
                          {2'h0, 2'h3, 4'hA, 11'h5EE}};
   int num_errors = 0, checks_done = 0, cyc = 0, starts = 0, n;
   pcs_regs_top dut (.*);
   // ************ tasks ************
   task automatic cmp(input logic [19:0] g, input logic [19:0] e);
      checks_done++;
      if (g !== e)
      begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      reg_wr_i <= 1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge clk_sys_i);
      reg_wr_i <= 0;
      repeat (3) @(posedge clk_sys_i); // derived outputs lag two edges
      #1;
   endtask
   // the expected word is queued before the strobe goes out
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      q.push_back(e);
      reg_rd_i <= 1;
      reg_addr_i <= a;
      @(posedge clk_sys_i);
      reg_rd_i <= 0;
      @(posedge clk_sys_i);
      #1;
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // ************ clock, read monitor, timeout ************
   initial
   begin
      forever #2 clk_sys_i = ~clk_sys_i;
   end
   always @(posedge clk_sys_i)
   begin
      rd_d <= reg_rd_i;
      cyc++;
      starts += gen_single_start_o; // the one-cycle pulse is easy to miss otherwise
      if (rd_d)
         cmp(reg_rdata_o, q.pop_front());
      if (cyc == 90000)
      begin
         num_errors++;
         report_and_stop();
      end
   end
   // ************ main sequence ************
   initial
   begin
      n = $urandom(83);
      repeat (16) @(posedge clk_sys_i);
      sys_rst_i <= 0;
      repeat (2) @(posedge clk_sys_i);
      #1;
      rd(8'h50, 16'h2947);
      rd(8'h54, 16'h0000);
      rd(8'h51, 16'h0000);
      wr(8'h50, 16'hFFFF);
      rd(8'h50, 16'h2F47);
      // wrap mode goes in first, before any random payload is asked for
      wr(8'h58, 16'h8F00);
      rd(8'h58, 16'h8000);
      $display("reset and reserved done");
      no_energy_cd_i <= 1;
      link_fail_1g_i <= 1;
      link_fail_100m_i <= 1;
      for (int i = 0; i < 4; i++)
      begin
         irq_event_i <= 1'($urandom);
         wr(8'h50, {2'h0, i[0], 1'b0, i[1:0], 1'b1, i[1], 1'b0, i[0], 6'h00});
         cmp({downshift_attempts_o, irq_pin_o, fallback_pair_o, fallback_10m_o, downshift_en_o},
         {4'h1 << i, irq_event_i ^ i[0], i[1], i[0], 1'b1});
      end
      $display("fallback config done");
      wr(8'h54, 16'h0000);
      rx_frame_err_i <= 1;
      rx_frame_end_i <= 1;
      repeat (3) @(posedge clk_sys_i);
      rx_frame_end_i <= 0;
      rd(8'h54, 16'h0003);
      rx_frame_end_i <= 1;
      repeat (65536) @(posedge clk_sys_i); // enough hits to pass all ones
      rx_frame_end_i <= 0;
      rd(8'h54, 16'hFFFF);
      wr(8'h54, 16'($urandom));
      rd(8'h54, 16'h0000);
      $display("fault tally done");
      prbs_cnt_max_i <= 2'h3;
      for (int k = 0; k < 3; k++)
      begin
         n = starts;
         wr(8'h58, tw[k]);
         repeat (4) @(posedge clk_sys_i);
         cmp({2'(starts - n), prbs_cnt_restart_o, prbs_wrap_pulse_o, prbs_gen_en_o,
              prbs_check_en_o, gen_continuous_o, frame_len_o},
             te[k]);
      end
      $display("generator done");
      speed_100m_i <= 1;
      // coding loop is 00 whenever the loop point moves; forward bits only in their own loop
      for (int j = 0; j < 4; j++)
      begin
         lp = 4'h1 << j;
         wr(8'h58, {10'h000, lp, 2'b00});
         cmp({loop_point_o, rx_to_mac_o, tx_to_line_o},
             {lp, j != 3, j != 0});
         wr(8'h58, {8'h00, j == 3, j == 0, lp, j[1:0]});
         cmp({rx_to_mac_o, tx_to_line_o, loop_post_encoder_o, loop_post_scrambler_o,
              loop_pre_scrambler_o, loop_pre_dsp_o},
             {2'b11, lp[3:1], 1'b0});
         wr(8'h58, {10'h000, lp, 2'b00});
      end
      speed_gig_i <= 1;
      speed_100m_i <= 0;
      wr(8'h58, 16'h0021);
      cmp({loop_pre_dsp_o, loop_post_encoder_o}, 2'b10);
      $display("loopback done");
      report_and_stop();
   end
endmodule
